// *** rtl/ca_parity_pkg.sv ***
// Purpose: shared constants, types and helpers for the command/address parity link
// Assumes: frame = {stack[2:0], activate_cmd_n, bank_group[1:0], bank_addr[1:0], addr[17:0]}
// Notes: addr[16:14] carry the row, column and write strobes
package ca_parity_pkg;
  // frame layout
  localparam int FRAME_W = 26;
  localparam int A_LSB = 0;
  localparam int BA_LSB = 18;
  localparam int BG_LSB = 20;
  localparam int ACT_BIT = 22;
  localparam int C_LSB = 23;
  localparam int STROBE_LSB = 14;
  // stacking pins are unconnected on this part, so they count as zero
  localparam logic [FRAME_W-1:0] COVER_MASK = 26'h07FFFFF;
  // command codes on {activate_cmd_n, row, col, write strobes}
  localparam logic [3:0] CMD_MODE_SET = 4'h8;
  localparam logic [3:0] CMD_READ = 4'hD;
  // mode register five: selected by {bank_group[0], bank_addr}
  localparam logic [2:0] MR5_SEL = 3'h5;
  localparam int PL_LSB = 0;
  localparam int WCRC_BIT = 3;
  localparam int PSTAT_BIT = 4;
  localparam int PERSIST_BIT = 9;
  localparam logic [2:0] PL_RESET = 3'h0;
  // command hold depth
  localparam int PIPE_D = 8;
  // timing, ns and derived pclk cycles
  localparam int CLK_NS = 10;
  localparam int PW_MIN_NS = 640;
  localparam int PW_MAX_NS = 1280;
  localparam int ROW_ACT_NS = 320;
  localparam logic [7:0] PW_MIN_CYC = 8'((PW_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] PW_MAX_CYC = 8'(PW_MAX_NS / CLK_NS);
  localparam logic [7:0] ROW_ACT_CYC = 8'((ROW_ACT_NS + CLK_NS - 1) / CLK_NS);
  // link clock half period in pclk cycles, less one
  localparam logic [1:0] LINK_HALF_M1 = 2'h3;
  // host register map
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] FRAME_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  typedef enum logic [1:0] {ST_RUN = 2'b00, ST_ALERT = 2'b01, ST_HOLD = 2'b10} dev_state_t;
  typedef enum logic [1:0] {C_IDLE = 2'b00, C_DIS = 2'b01, C_SEND = 2'b10} ctl_state_t;
  // even parity over the covered frame bits
  function automatic logic parity_of(input logic [FRAME_W-1:0] f);
    parity_of = ^(f & COVER_MASK);
  endfunction
  // parity delay code to link cycles
  function automatic logic [3:0] pl_cycles(input logic [2:0] code);
    case (code)
      3'h1: pl_cycles = 4'h4;
      3'h2: pl_cycles = 4'h5;
      3'h3: pl_cycles = 4'h6;
      3'h4: pl_cycles = 4'h8;
      default: pl_cycles = 4'h0;
    endcase
  endfunction
endpackage

// *** rtl/ca_link_if.sv ***
// Purpose: command/address link between controller and memory device
// Assumes: alert line is open drain with a pull-up
// Notes: only the device drives the alert line, and only low
`timescale 1ns/1ps
interface ca_link_if;
  import ca_parity_pkg::*;
  logic ck;
  logic cs_n;
  logic clock_enable_in;
  logic termination_ctrl;
  logic [FRAME_W-1:0] frame;
  logic ca_parity_in;
  logic alert_o;
  logic alert_oe;
  wire error_alert_out = alert_oe ? alert_o : 1'b1;
  modport dev (input ck, cs_n, clock_enable_in, termination_ctrl, frame, ca_parity_in, error_alert_out,
    output alert_o, alert_oe);
  modport ctl (output ck, cs_n, clock_enable_in, termination_ctrl, frame, ca_parity_in,
    input error_alert_out);
endinterface

// *** rtl/ca_parity_checker.sv ***
// Purpose: device end; delays, checks and executes commands, raises the alert on parity errors
// Assumes: link clock well below pclk/6 so three-stage sampling sees every edge
// Notes: commands still in the hold line at an error are dropped, never executed
`timescale 1ns/1ps
module ca_parity_checker import ca_parity_pkg::*; (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // link
  ca_link_if.dev link,
  // core settings and events
  input wire logic dll_en,
  input wire logic [4:0] cas_lat,
  input wire logic [4:0] add_lat,
  input wire logic [4:0] cwl,
  input wire logic crc_en,
  input wire logic wcrc_err,
  // executed commands
  output logic exec_valid_r,
  output logic [FRAME_W-1:0] exec_frame_r,
  output logic dqs_en_r,
  output logic prech_all_r,
  // mode and status
  output logic [5:0] rd_lat_r,
  output logic [5:0] wr_lat_r,
  output logic [2:0] pl_code_r,
  output logic persist_r,
  output logic pstat_r,
  output logic wcrc_stat_r,
  output logic check_on_r,
  output logic [FRAME_W:0] err_log_r
);
  localparam int SW = FRAME_W + 3;
  logic [SW-1:0] s1_r, s2_r, s3_r;
  logic ck_lvl_r;
  logic rise;
  logic accept;
  logic par_bad;
  logic err;
  logic take;
  logic [FRAME_W-1:0] f3;
  logic [3:0] plc;
  dev_state_t state_r;
  logic [7:0] cnt_r;
  logic precharged_r;
  logic [PIPE_D-1:0] pv_r;
  logic [FRAME_W-1:0] pd_r [PIPE_D];
  logic ex_now;
  logic [FRAME_W-1:0] ex_frame;
  logic mr5_wr;

  // three-stage sampling of ck, cs_n, parity and frame (not cke or odt); ck sits on top
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= {link.ck, link.cs_n, link.ca_parity_in, link.frame};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ck level follows only once stages two and three agree; reset high like the stages, so no false rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_lvl_r <= 1'b1;
    end else if (s2_r[SW-1] == s3_r[SW-1]) begin
      ck_lvl_r <= s3_r[SW-1];
    end
  end

  // capture on rising ck with select low
  assign rise = s2_r[SW-1] & s3_r[SW-1] & ~ck_lvl_r;
  assign accept = rise & ~s3_r[SW-2];
  assign f3 = s3_r[FRAME_W-1:0];
  assign plc = pl_cycles(pl_code_r);
  assign par_bad = parity_of(f3) ^ s3_r[FRAME_W];
  assign err = accept & check_on_r & par_bad & (state_r == ST_RUN);
  // nothing new is taken while the alert cycle runs
  assign take = accept & ~err & (state_r == ST_RUN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      check_on_r <= 1'b0;
    end else begin
      check_on_r <= (pl_code_r != PL_RESET) & dll_en & (~pstat_r | (persist_r & (state_r != ST_ALERT)));
    end
  end

  // hold line, one stage per link cycle
  generate
    for (genvar i = 0; i < PIPE_D; i++) begin : g_hold
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pv_r[i] <= 1'b0;
          pd_r[i] <= '0;
        end else if (err) begin
          // held commands, reads included, are dropped
          pv_r[i] <= 1'b0;
        end else if (rise) begin
          if (i == 0) begin
            pv_r[i] <= take & (plc != 4'h0);
            pd_r[i] <= f3;
          end else begin
            pv_r[i] <= pv_r[(i == 0) ? 0 : i - 1];
            pd_r[i] <= pd_r[(i == 0) ? 0 : i - 1];
          end
        end
      end
    end
  endgenerate

  // execution point: at capture when delay is off, else after plc link cycles
  always_comb begin
    ex_now = 1'b0;
    ex_frame = f3;
    if (plc == 4'h0) begin
      ex_now = take;
    end else if (rise && !err) begin
      ex_now = pv_r[3'(plc - 4'h1)];
      ex_frame = pd_r[3'(plc - 4'h1)];
    end
  end

  assign mr5_wr = ex_now && {ex_frame[ACT_BIT], ex_frame[STROBE_LSB+2:STROBE_LSB]} == CMD_MODE_SET
    && {ex_frame[BG_LSB], ex_frame[BA_LSB+1:BA_LSB]} == MR5_SEL;

  // executed command strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_valid_r <= 1'b0;
      exec_frame_r <= '0;
      dqs_en_r <= 1'b0;
    end else begin
      exec_valid_r <= ex_now;
      exec_frame_r <= ex_now ? ex_frame : exec_frame_r;
      // strobes only for a read that really executes
      dqs_en_r <= ex_now & ({ex_frame[ACT_BIT], ex_frame[STROBE_LSB+2:STROBE_LSB]} == CMD_READ);
    end
  end

  // mode register five fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pl_code_r <= PL_RESET;
      persist_r <= 1'b0;
    end else if (mr5_wr) begin
      // delay field is write-only from the link side
      pl_code_r <= ex_frame[PL_LSB+2:PL_LSB];
      persist_r <= ex_frame[PERSIST_BIT];
    end
  end

  // parity error status; a set in the same cycle as a clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstat_r <= 1'b0;
    end else if (err) begin
      // status set at detection, long before release
      pstat_r <= 1'b1;
    end else if (mr5_wr && !ex_frame[PSTAT_BIT]) begin
      // only a zero is honoured, a one is blocked
      pstat_r <= 1'b0;
    end
  end

  // write CRC status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcrc_stat_r <= 1'b0;
    end else if (err && crc_en) begin
      // parity error resets write CRC status while crc_en is high
      wcrc_stat_r <= 1'b0;
    end else if (wcrc_err && crc_en) begin
      wcrc_stat_r <= 1'b1;
    end else if (mr5_wr && !ex_frame[WCRC_BIT]) begin
      wcrc_stat_r <= 1'b0;
    end
  end

  // log holds the latest erroneous frame and parity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_log_r <= '0;
    end else if (err) begin
      err_log_r <= {s3_r[FRAME_W], f3};
    end
  end

  // parity delay folds into both latencies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_lat_r <= '0;
      wr_lat_r <= '0;
    end else begin
      rd_lat_r <= 6'(add_lat) + 6'(cas_lat) + 6'(plc);
      wr_lat_r <= 6'(add_lat) + 6'(cwl) + 6'(plc);
    end
  end

  // alert sequence: assert, precharge after row time, release, wait out maximum width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RUN;
      cnt_r <= '0;
      precharged_r <= 1'b0;
      prech_all_r <= 1'b0;
    end else begin
      prech_all_r <= 1'b0;
      case (state_r)
        ST_RUN: begin
          cnt_r <= '0;
          precharged_r <= 1'b0;
          if (err) begin
            state_r <= ST_ALERT;
          end
        end
        ST_ALERT: begin
          cnt_r <= cnt_r + 8'h01;
          // close all pages once row time has passed
          if (cnt_r == ROW_ACT_CYC - 8'h01) begin
            prech_all_r <= 1'b1;
            precharged_r <= 1'b1;
          end
          // release after minimum width and precharge
          if (cnt_r >= PW_MIN_CYC - 8'h01 && precharged_r) begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cnt_r <= cnt_r + 8'h01;
          // normal commands resume after maximum width
          if (cnt_r >= PW_MAX_CYC - 8'h01) begin
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  // alert driven low from the cycle after detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.alert_oe <= 1'b0;
    end else begin
      link.alert_oe <= err | (state_r == ST_ALERT && !(cnt_r >= PW_MIN_CYC - 8'h01 && precharged_r));
    end
  end
  assign link.alert_o = 1'b0; // open drain: only ever pulls low

endmodule // ca_parity_checker

// *** rtl/ca_parity_host.sv ***
// Purpose: controller end; sends frames with even parity, backs off on alert
// Assumes: software programs frames through the APB registers
// Notes: link clock made here by dividing pclk by eight
`timescale 1ns/1ps
module ca_parity_host import ca_parity_pkg::*; (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  ca_link_if.ctl link
);
  logic [FRAME_W-1:0] frame_r;
  logic go_r, inject_r, cke_r, odt_r, alert_seen_r;
  logic [2:0] pl_shadow_r;
  logic a1_r, a2_r, a3_r, alert_lvl_r;
  logic [1:0] div_r;
  logic [3:0] dis_wait_r;
  logic ck_r, fall, wr_acc, done, is_mr5, need_dis;
  ctl_state_t st_r;

  // zero-wait slave: read data and error registered at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~(paddr == CTRL_OFF || paddr == FRAME_OFF || paddr == STAT_OFF);
      case (paddr)
        CTRL_OFF: prdata <= {29'h0, odt_r, cke_r, inject_r};
        FRAME_OFF: prdata <= {6'h0, frame_r};
        STAT_OFF: prdata <= {25'h0, pl_shadow_r, 1'b0, ~alert_lvl_r, alert_seen_r, go_r};
        default: prdata <= '0;
      endcase
    end
  end
  assign wr_acc = psel & penable & pready & pwrite;

  // configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_r <= '0;
      inject_r <= 1'b0;
      cke_r <= 1'b0;
      odt_r <= 1'b0;
    end else if (wr_acc && paddr == FRAME_OFF) begin
      frame_r <= pwdata[FRAME_W-1:0];
    end else if (wr_acc && paddr == CTRL_OFF) begin
      inject_r <= pwdata[1];
      cke_r <= pwdata[2];
      odt_r <= pwdata[3];
    end
  end

  // go: set by software, ended by the sequencer; the set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_r <= 1'b0;
    end else if (wr_acc && paddr == CTRL_OFF && pwdata[0]) begin
      go_r <= 1'b1;
    end else if (done) begin
      go_r <= 1'b0;
    end
  end

  // alert pin sampled through three stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a1_r <= 1'b1;
      a2_r <= 1'b1;
      a3_r <= 1'b1;
      alert_lvl_r <= 1'b1;
    end else begin
      a1_r <= link.error_alert_out;
      a2_r <= a1_r;
      a3_r <= a2_r;
      alert_lvl_r <= (a2_r == a3_r) ? a3_r : alert_lvl_r;
    end
  end

  // refreshes owed flag
  // sticky alert seen, write one to clear; also flags that refreshes may be owed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_seen_r <= 1'b0;
    end else if (!alert_lvl_r) begin
      alert_seen_r <= 1'b1;
    end else if (wr_acc && paddr == STAT_OFF && pwdata[1]) begin
      alert_seen_r <= 1'b0;
    end
  end

  // link clock divider; frames change on the falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
      ck_r <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      if (div_r == LINK_HALF_M1) begin
        ck_r <= ~ck_r;
      end
    end
  end
  assign fall = (div_r == LINK_HALF_M1) & ck_r;
  assign link.ck = ck_r;

  // a nonzero-to-nonzero delay change goes through disabled first
  assign is_mr5 = {frame_r[ACT_BIT], frame_r[STROBE_LSB+2:STROBE_LSB]} == CMD_MODE_SET
    && {frame_r[BG_LSB], frame_r[BA_LSB+1:BA_LSB]} == MR5_SEL;
  assign need_dis = is_mr5 && pl_shadow_r != PL_RESET && frame_r[PL_LSB+2:PL_LSB] != PL_RESET
    && frame_r[PL_LSB+2:PL_LSB] != pl_shadow_r;
  assign done = fall & (st_r == C_SEND | (~alert_lvl_r & go_r));

  // frame sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= C_IDLE;
      pl_shadow_r <= PL_RESET;
      dis_wait_r <= '0;
      link.cs_n <= 1'b1;
      link.frame <= '0;
      link.ca_parity_in <= 1'b0;
    end else if (fall) begin
      link.cs_n <= 1'b1;
      // alert low: deselect only, pending frame abandoned
      if (!alert_lvl_r) begin
        st_r <= C_IDLE;
      end else begin
        case (st_r)
          C_IDLE: begin
            if (go_r) begin
              link.cs_n <= 1'b0;
              link.frame <= need_dis ? {frame_r[FRAME_W-1:PL_LSB+3], PL_RESET} : frame_r;
              // even parity, optionally spoiled for testing
              link.ca_parity_in <= parity_of(need_dis ? {frame_r[FRAME_W-1:PL_LSB+3], PL_RESET} : frame_r)
                ^ inject_r;
              st_r <= need_dis ? C_DIS : C_SEND;
              dis_wait_r <= 4'(PIPE_D);
            end
          end
          C_DIS: begin
            // the disable must leave the hold line before the new delay is sent
            if (dis_wait_r != 4'h0) begin
              dis_wait_r <= dis_wait_r - 4'h1;
            end else begin
              link.cs_n <= 1'b0;
              link.frame <= frame_r;
              link.ca_parity_in <= parity_of(frame_r) ^ inject_r;
              st_r <= C_SEND;
            end
          end
          C_SEND: begin
            if (is_mr5) begin
              pl_shadow_r <= frame_r[PL_LSB+2:PL_LSB];
            end
            st_r <= C_IDLE;
          end
          default: begin
            st_r <= C_IDLE;
          end
        endcase
      end
    end
  end
  assign link.clock_enable_in = cke_r;
  assign link.termination_ctrl = odt_r;

endmodule // ca_parity_host

// *** test/ca_parity_checker_monitor.sv ***
// Purpose: concurrent checks on the alert line and device status
// Assumes: alert_oe high means the device pulls the alert line low
// Notes: pulse widths are counted in pclk cycles
`timescale 1ns/1ps
module ca_parity_checker_monitor import ca_parity_pkg::*; (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // link and device status
  input wire logic alert_oe,
  input wire logic error_alert_out,
  input wire logic exec_valid_r,
  input wire logic prech_all_r,
  input wire logic persist_r,
  input wire logic pstat_r,
  input wire logic wcrc_stat_r,
  input wire logic check_on_r,
  input wire logic crc_en,
  input wire logic [FRAME_W:0] err_log_r
);
  logic [7:0] pw_cnt_r;
  logic prech_seen_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles the alert has been held; saturates so a stuck alert cannot wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pw_cnt_r <= 8'h00;
    else if (!alert_oe) pw_cnt_r <= 8'h00;
    else if (pw_cnt_r != 8'hFF) pw_cnt_r <= pw_cnt_r + 8'h01;
  end
  // remembers a precharge-all inside the current alert
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prech_seen_r <= 1'b0;
    else prech_seen_r <= alert_oe & (prech_seen_r | prech_all_r);
  end
  chk_alert_drive_low: assert property (alert_oe |-> !error_alert_out)
    else $error("alert enabled but line not low");
  chk_status_on_alert: assert property ($rose(alert_oe) |-> pstat_r)
    else $error("status bit not set with alert");
  chk_log_odd_parity: assert property ($rose(alert_oe) |->
    ^{err_log_r[FRAME_W], err_log_r[FRAME_W-1:0] & COVER_MASK})
    else $error("logged frame has even parity");
  chk_crc_status_reset: assert property ($rose(alert_oe) && crc_en |-> ##[0:1] !wcrc_stat_r)
    else $error("crc status kept after parity error");
  chk_alert_min_width: assert property ($fell(alert_oe) |-> pw_cnt_r >= PW_MIN_CYC)
    else $error("alert released too early");
  chk_release_after_prech: assert property ($fell(alert_oe) |-> prech_seen_r)
    else $error("alert released before precharge");
  chk_alert_max_width: assert property (alert_oe |-> pw_cnt_r < PW_MAX_CYC)
    else $error("alert held too long");
  chk_no_exec_alert: assert property (alert_oe && $past(alert_oe) |-> !exec_valid_r)
    else $error("command executed during alert");
  chk_resume_mode: assert property ($fell(alert_oe) |-> ##[0:70] (check_on_r == persist_r))
    else $error("checking state wrong after alert");
  chk_log_kept: assert property ($changed(err_log_r) |-> $rose(alert_oe))
    else $error("error log changed without an error");
  // main scenarios reached
  cov_alert: cover property ($rose(alert_oe));
  cov_persist_release: cover property ($fell(alert_oe) && persist_r);
  cov_exec: cover property (exec_valid_r && check_on_r);
endmodule // ca_parity_checker_monitor

// *** test/ca_parity_checker_tb.sv ***
// Purpose: drives host end over APB, checks the device end across the link
// Assumes: link clock runs free from the host divider
// Notes: notes of expected frames are queued by the driver, popped on exec
`timescale 1ns/1ps
module ca_parity_checker_tb import ca_parity_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic dll_en, crc_en, wcrc_err;
  logic [4:0] cas_lat, add_lat, cwl;
  logic exec_valid_r, dqs_en_r, prech_all_r, persist_r, pstat_r, wcrc_stat_r, check_on_r;
  logic [FRAME_W-1:0] exec_frame_r;
  logic [5:0] rd_lat_r, wr_lat_r;
  logic [2:0] pl_code_r;
  logic [FRAME_W:0] err_log_r;
  int failures = 0, checked = 0, seed = 20445, cur_pl = 0, rise_cnt = 0, prech_cnt = 0;
  int pl_tab[5] = '{0, 4, 5, 6, 8};
  logic ck_q = 1'b0;
  logic [FRAME_W-1:0] fq[$];
  int tq[$];
  ca_link_if link();
  ca_parity_checker u_ca_parity_checker(.pclk, .presetn, .link(link), .dll_en, .cas_lat, .add_lat, .cwl,
    .crc_en, .wcrc_err, .exec_valid_r, .exec_frame_r, .dqs_en_r, .prech_all_r, .rd_lat_r, .wr_lat_r,
    .pl_code_r, .persist_r, .pstat_r, .wcrc_stat_r, .check_on_r, .err_log_r);
  ca_parity_host u_ca_parity_host(.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .link(link));
  ca_parity_checker_monitor u_ca_parity_checker_monitor(.pclk, .presetn, .alert_oe(link.alert_oe),
    .error_alert_out(link.error_alert_out), .exec_valid_r, .prech_all_r, .persist_r, .pstat_r,
    .wcrc_stat_r, .check_on_r, .crc_en, .err_log_r);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic is_mrs(input logic [FRAME_W-1:0] f);
    return {f[22], f[16:14]} == CMD_MODE_SET;
  endfunction
  // one APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic err);
    int n;
    n = 0;
    psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n == 20) cmp("pready", 1, 0);
    q = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // sends one frame through the host and waits until it is no longer busy
  task automatic send(input logic [FRAME_W-1:0] f, input logic bad);
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    apb(1'b1, FRAME_OFF, 32'(f), q, e);
    apb(1'b1, CTRL_OFF, {28'h0, 2'($random(seed)), bad, 1'b1}, q, e);
    do begin apb(1'b0, STAT_OFF, 32'h0, q, e); n++; end while (q[0] !== 1'b0 && n < 60);
    cmp("host busy", 0, 32'(q[0]));
  endtask
  task automatic rand_frame(output logic [FRAME_W-1:0] f);
    f = 26'($random(seed));
    f[22] = f[0];
    if (f[0]) f[16:14] = 3'b101;
  endtask
  // eight delayed rises of the 80 ns link clock fit inside the wait
  task automatic setmode(input logic [2:0] c, input logic st, input logic per);
    logic [FRAME_W-1:0] f;
    f = '0; f[22] = 1'b1; f[20] = 1'b1; f[18] = 1'b1; f[2:0] = c; f[4] = st; f[9] = per;
    send(f, 1'b0);
    repeat (90) @(posedge pclk);
    cur_pl = pl_tab[c];
    cmp("delay code", 32'(c), 32'(pl_code_r));
    cmp("persist mode", 32'(per), 32'(persist_r));
  endtask
  task automatic wait_alert(input logic lvl);
    int n;
    n = 0;
    while (link.error_alert_out !== lvl && n < 400) begin @(posedge pclk); n++; end
    cmp("alert level", 32'(lvl), 32'(link.error_alert_out));
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (fq.size() != 0 && n < 200) begin @(posedge pclk); n++; end
    cmp("pending frames", 0, fq.size());
  endtask
  // counts link clock rises, notes taken commands and checks every exec other than a mode set
  always @(posedge pclk) begin : watch
    logic [FRAME_W-1:0] f;
    int t;
    if (exec_valid_r === 1'b1 && !is_mrs(exec_frame_r)) begin
      if (fq.size() == 0 || tq.size() == 0) cmp("unexpected exec", 0, 1);
      else begin
        f = fq.pop_front();
        t = tq.pop_front();
        cmp("exec frame", 32'(f & COVER_MASK), 32'(exec_frame_r & COVER_MASK));
        cmp("read strobe", 32'({f[22], f[16:14]} == CMD_READ), 32'(dqs_en_r));
        cmp("hold delay", cur_pl, rise_cnt - t);
      end
    end
    ck_q <= link.ck;
    if (prech_all_r === 1'b1) prech_cnt = prech_cnt + 1;
    if (link.ck === 1'b1 && ck_q === 1'b0) begin
      rise_cnt = rise_cnt + 1;
      if (link.cs_n === 1'b0 && !is_mrs(link.frame)) tq.push_back(rise_cnt);
    end
  end
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    conclude();
  end
  initial begin : main
    logic [FRAME_W-1:0] f;
    logic [31:0] q;
    logic e;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    dll_en = 1'b1; crc_en = 1'b0; wcrc_err = 1'b0; cas_lat = 5'h0B; add_lat = 5'h00; cwl = 5'h09;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h0C, 32'h0, q, e);
    cmp("unmapped error", 1, 32'(e));
    cmp("unmapped data", 0, q);
    // delay codes 0 to 4, with random latencies and random frames
    for (int c = 0; c < 5; c++) begin
      cas_lat <= 5'($random(seed)) & 5'h0F;
      add_lat <= 5'($random(seed)) & 5'h0F;
      cwl <= 5'($random(seed)) & 5'h0F;
      if (c > 0) setmode(3'(c), 1'b0, 1'b0);
      else repeat (3) @(posedge pclk);
      cmp("read latency", 32'(add_lat + cas_lat + pl_tab[c]), 32'(rd_lat_r));
      cmp("write latency", 32'(add_lat + cwl + pl_tab[c]), 32'(wr_lat_r));
      cmp("check enable", 32'(c != 0), 32'(check_on_r));
      repeat (2) begin
        rand_frame(f);
        fq.push_back(f);
        send(f, 1'b0);
        drain();
      end
    end
    // parity error with write crc status set beforehand
    crc_en <= 1'b1;
    wcrc_err <= 1'b1;
    @(posedge pclk);
    wcrc_err <= 1'b0;
    repeat (2) @(posedge pclk);
    cmp("crc status", 1, 32'(wcrc_stat_r));
    rand_frame(f);
    send(f, 1'b1);
    wait_alert(1'b0);
    wait_alert(1'b1);
    repeat (PW_MAX_CYC) @(posedge pclk);
    tq.delete();
    apb(1'b0, STAT_OFF, 32'h0, q, e);
    cmp("alert seen", 1, 32'(q[1]));
    cmp("status bit", 1, 32'(pstat_r));
    cmp("crc reset", 0, 32'(wcrc_stat_r));
    cmp("error log", 32'({~^(f & COVER_MASK), f & COVER_MASK}),
      32'({err_log_r[FRAME_W], err_log_r[FRAME_W-1:0] & COVER_MASK}));
    cmp("checking off", 0, 32'(check_on_r));
    cmp("precharge all", 1, prech_cnt);
    rand_frame(f);
    fq.push_back(f);
    send(f, 1'b1);
    drain();
    cmp("no alert", 1, 32'(link.error_alert_out));
    setmode(3'h4, 1'b0, 1'b0);
    cmp("status cleared", 0, 32'(pstat_r));
    cmp("checking on", 1, 32'(check_on_r));
    setmode(3'h4, 1'b1, 1'b0);
    cmp("status one blocked", 0, 32'(pstat_r));
    // persistent mode: second error is caught without clearing
    // log left unchecked after repeats
    setmode(3'h4, 1'b0, 1'b1);
    repeat (2) begin
      rand_frame(f);
      send(f, 1'b1);
      wait_alert(1'b0);
      wait_alert(1'b1);
      repeat (PW_MAX_CYC) @(posedge pclk);
      tq.delete();
      cmp("persist checking", 1, 32'(check_on_r));
      cmp("persist status", 1, 32'(pstat_r));
    end
    dll_en <= 1'b0;
    repeat (3) @(posedge pclk);
    cmp("checking without loop", 0, 32'(check_on_r));
    conclude();
  end
endmodule // ca_parity_checker_tb
